// file: logic/rtes_pkg.sv
`default_nettype none
package rtes_pkg;

    // ====================================================================
    // Register map
    localparam logic [7:0] STATUS_OFFSET = 8'h0f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int BIT_ANY = 6;
    localparam int BIT_Z_EVT = 5;
    localparam int BIT_Z_SIGN = 4;
    localparam int BIT_Y_EVT = 3;
    localparam int BIT_Y_SIGN = 2;
    localparam int BIT_X_EVT = 1;
    localparam int BIT_X_SIGN = 0;
    localparam int RATE_W = 16;
    localparam int LIMIT_W = 7;
    localparam int COUNT_W = 8;
    localparam int LIMIT_SHIFT = 8;
    localparam logic [7:0] DEBOUNCE_RESET = 8'h01;

    // ====================================================================
    // Operating modes
    typedef enum logic [1:0] {
        RTES_STANDBY = 2'b00,
        RTES_READY = 2'b01,
        RTES_ACTIVE = 2'b10
    } rtes_mode_t;

    // Configuration that all axes share.
    typedef struct packed {
        logic latchEnable;
        logic debounceClearMode;
        logic [LIMIT_W-1:0] rateLimitValue;
        logic [COUNT_W-1:0] debounceLength;
    } rtes_cfg_t;

    // Per-axis result handed to the status logic.
    typedef struct packed {
        logic hit;
        logic release_;
        logic sign;
    } rtes_axis_t;

endpackage
`default_nettype wire

// file: logic/rtes_axis.sv
`default_nettype none
module rtes_axis #(
    parameter int RW = rtes_pkg::RATE_W,
    parameter int CW = rtes_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic restart,
    input wire logic sample,
    input wire logic detectEnable,
    input wire logic [RW-1:0] rate,
    input wire rtes_pkg::rtes_cfg_t cfg,
    output rtes_pkg::rtes_axis_t result
);

    logic [RW:0] magnitude;
    logic [RW:0] limit;
    logic above;
    logic [CW-1:0] upCnt_q;
    logic [CW-1:0] downCnt_q;

    // Widened by one bit so that the most negative rate still fits.
    function automatic logic [RW:0] absOf(input logic [RW-1:0] v);
        logic [RW:0] e;
        e = {v[RW-1], v};
        return e[RW] ? (~e + 1'b1) : e;
    endfunction

    assign magnitude = absOf(rate);
    // ====================================================================
    // limit is (value+1)*256
    assign limit = (RW+1)'({1'b0, cfg.rateLimitValue} + 8'h01)
        << rtes_pkg::LIMIT_SHIFT;
    assign above = magnitude > limit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upCnt_q <= '0;
            downCnt_q <= '0;
        end else if (clkEn) begin
            if (restart || !detectEnable) begin
                upCnt_q <= '0;
                downCnt_q <= '0;
            end else if (sample) begin
                if (above) begin
                    downCnt_q <= '0;
                    if (upCnt_q < cfg.debounceLength) begin
                        upCnt_q <= upCnt_q + 1'b1;
                    end
                end else begin
                    if (downCnt_q < cfg.debounceLength) begin
                        downCnt_q <= downCnt_q + 1'b1;
                    end
                    if (cfg.debounceClearMode) begin
                        upCnt_q <= '0;
                    end else if (upCnt_q != '0) begin
                        upCnt_q <= upCnt_q - 1'b1;
                    end
                end
            end
        end
    end

    // A result is only meaningful in the cycle that a sample is taken.
    always_comb begin
        // Compared one bit wider so a full count of 255 cannot wrap to 0.
        result.hit = sample && detectEnable && above
            && ({1'b0, upCnt_q} + 1'b1 >= {1'b0, cfg.debounceLength});
        result.release_ = sample && !above
            && ({1'b0, downCnt_q} + 1'b1 >= {1'b0, cfg.debounceLength});
        result.sign = rate[RW-1];
    end

endmodule
`default_nettype wire

// file: logic/rtes_event_source.sv
`default_nettype none
module rtes_event_source #(
    parameter int RW = rtes_pkg::RATE_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic sampleStrobe,
    input wire logic [RW-1:0] xRate,
    input wire logic [RW-1:0] yRate,
    input wire logic [RW-1:0] zRate,
    input wire rtes_pkg::rtes_mode_t opMode,
    input wire logic flagLatchEnable,
    input wire logic xDetectEnable,
    input wire logic yDetectEnable,
    input wire logic zDetectEnable,
    input wire logic debounceClearMode,
    input wire logic [rtes_pkg::LIMIT_W-1:0] rateLimitValue,
    input wire logic [rtes_pkg::COUNT_W-1:0] debounceLength,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    output logic [7:0] readData,
    output logic readValid,
    output logic anyAxisEvent
);

    rtes_pkg::rtes_cfg_t cfg;
    rtes_pkg::rtes_mode_t prevMode_q;
    rtes_pkg::rtes_axis_t res [3];
    logic [2:0] enables;
    logic [2:0] event_q;
    logic [2:0] sign_q;
    logic any_q;
    logic restart;
    logic statusRead;
    logic [7:0] status;

    assign cfg.latchEnable = flagLatchEnable;
    assign cfg.debounceClearMode = debounceClearMode;
    assign cfg.rateLimitValue = rateLimitValue;
    assign cfg.debounceLength = debounceLength;
    assign enables = {zDetectEnable, yDetectEnable, xDetectEnable};

    // ====================================================================
    // Mode tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevMode_q <= rtes_pkg::RTES_STANDBY;
        end else if (clkEn) begin
            prevMode_q <= opMode;
        end
    end

    assign restart = (opMode == rtes_pkg::RTES_ACTIVE)
        && (prevMode_q != rtes_pkg::RTES_ACTIVE);
    assign statusRead = regRead && (regAddr == rtes_pkg::STATUS_OFFSET);

    // ====================================================================
    // Axes: index 0 is X, 1 is Y, 2 is Z.
    rtes_axis #(.RW(RW), .CW(rtes_pkg::COUNT_W)) u_x (
        .clk(clk), .rst(rst), .clkEn(clkEn), .restart(restart),
        .sample(sampleStrobe), .detectEnable(xDetectEnable),
        .rate(xRate), .cfg(cfg), .result(res[0])
    );
    rtes_axis #(.RW(RW), .CW(rtes_pkg::COUNT_W)) u_y (
        .clk(clk), .rst(rst), .clkEn(clkEn), .restart(restart),
        .sample(sampleStrobe), .detectEnable(yDetectEnable),
        .rate(yRate), .cfg(cfg), .result(res[1])
    );
    rtes_axis #(.RW(RW), .CW(rtes_pkg::COUNT_W)) u_z (
        .clk(clk), .rst(rst), .clkEn(clkEn), .restart(restart),
        .sample(sampleStrobe), .detectEnable(zDetectEnable),
        .rate(zRate), .cfg(cfg), .result(res[2])
    );

    // ====================================================================
    // Event and sign flags. A new detection in the read cycle wins over
    // the read-to-clear, so no event is lost.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_q <= '0;
            sign_q <= '0;
        end else if (clkEn) begin
            if (restart) begin
                event_q <= '0;
                sign_q <= '0;
            end else begin
                for (int i = 0; i < 3; i++) begin
                    if (!enables[i]) begin
                        event_q[i] <= 1'b0;
                    end else if (res[i].hit) begin
                        event_q[i] <= 1'b1;
                    end else if (flagLatchEnable && statusRead) begin
                        event_q[i] <= 1'b0;
                    end else if (!flagLatchEnable && res[i].release_) begin
                        event_q[i] <= 1'b0;
                    end
                    if (!enables[i]) begin
                        sign_q[i] <= 1'b0;
                    end else if (sampleStrobe) begin
                        sign_q[i] <= res[i].sign;
                    end else if (flagLatchEnable && statusRead) begin
                        sign_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // combined flag follows axis flags, cleared with them on latched read or restart, one cycle after them on release or disable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_q <= 1'b0;
        end else if (clkEn) begin
            if (restart) begin
                any_q <= 1'b0;
            end else if (flagLatchEnable && statusRead) begin
                any_q <= |({res[2].hit, res[1].hit, res[0].hit} & enables);
            end else begin
                any_q <= |(event_q | ({res[2].hit, res[1].hit, res[0].hit}
                    & enables));
            end
        end
    end

    assign status = {1'b0, any_q, event_q[2], sign_q[2], event_q[1],
        sign_q[1], event_q[0], sign_q[0]};

    // ====================================================================
    // capture before clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readData <= rtes_pkg::STATUS_RESET;
            readValid <= 1'b0;
        end else if (clkEn) begin
            readValid <= regRead;
            if (regRead) begin
                readData <= statusRead ? status : 8'h00;
            end
        end
    end

    assign anyAxisEvent = any_q;

endmodule
`default_nettype wire

// file: testbench/rtes_event_source_props.sv
`default_nettype none
module rtes_event_source_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic sampleStrobe,
    input wire rtes_pkg::rtes_mode_t opMode,
    input wire logic flagLatchEnable,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] readData,
    input wire logic readValid,
    input wire logic anyAxisEvent
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================================
    // Register read checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic statusRd;
    assign statusRd = regRead && clkEn && regAddr == rtes_pkg::STATUS_OFFSET;
    // Samples are kept out of the window, since a sample may legally re-set.
    sequence quiet_rd_s;
        statusRd && !sampleStrobe;
    endsequence
    sequence latched_rd_s;
        statusRd && flagLatchEnable && !sampleStrobe ##1 !sampleStrobe;
    endsequence
    sequence entry_s;
        opMode == rtes_pkg::RTES_ACTIVE && clkEn && !sampleStrobe
            && $past(opMode) != rtes_pkg::RTES_ACTIVE;
    endsequence
    valid_follows_a:
        assert property (regRead && clkEn |=> readValid)
        else $error("no answer");
    valid_cause_a:
        assert property (readValid |-> $past(regRead && clkEn))
        else $error("stray valid");
    top_bit_a:
        assert property (readValid |-> !readData[7])
        else $error("bit 7 set");
    unmapped_zero_a:
        assert property (regRead && clkEn
            && regAddr != rtes_pkg::STATUS_OFFSET |=> readData == 8'h00)
        else $error("unmapped data");
    data_hold_a:
        assert property (!readValid |-> $stable(readData))
        else $error("data moved");
    any_event_a:
        assert property (statusRd |=> readData[6] == $past(anyAxisEvent))
        else $error("bit 6 differs");
    latch_clear_a:
        assert property (latched_rd_s ##1 quiet_rd_s |=> readData == 8'h00)
        else $error("latched not cleared");
    mode_entry_a:
        assert property (entry_s ##1 quiet_rd_s |=> readData == 8'h00)
        else $error("entry not cleared");
    any_clear_a:
        assert property (statusRd && flagLatchEnable && !sampleStrobe
            |=> !anyAxisEvent)
        else $error("combined flag kept");
endmodule
bind rtes_event_source rtes_event_source_props chk (
    .clk(clk), .rst(rst), .clkEn(clkEn), .sampleStrobe(sampleStrobe),
    .opMode(opMode), .flagLatchEnable(flagLatchEnable), .regRead(regRead),
    .regAddr(regAddr), .readData(readData), .readValid(readValid),
    .anyAxisEvent(anyAxisEvent)
);
`default_nettype wire

// file: testbench/rtes_host.sv
`default_nettype none
module rtes_host (
    input wire logic clk,
    input wire logic [7:0] readData,
    input wire logic readValid,
    output logic regRead,
    output logic [7:0] regAddr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk) #1;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clk) #1;
        v = readValid;
        d = readData;
        regRead = 1'b0;
        // A released address shows its inverse so nothing leans on a stale one.
        regAddr = ~a;
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, sampleStrobe = 1'b0, latchEn = 1'b0;
    logic dbMode = 1'b1, regRead, rdValid, anyEvt;
    logic [15:0] xRate = 16'h0000, yRate = 16'h0000, zRate = 16'h0000;
    logic [15:0] lfsr = 16'h0030, t;
    rtes_pkg::rtes_mode_t opMode = rtes_pkg::RTES_STANDBY;
    logic [2:0] detEn = 3'b111;
    logic [6:0] limit = 7'h00;
    logic [7:0] dbLen = 8'h03, regAddr, rdData;
    int fails = 0, comparisons = 0;
    localparam logic [7:0] OFF = rtes_pkg::STATUS_OFFSET;
    always #25 clk = ~clk;
    rtes_event_source uut (.clk(clk), .rst(rst), .clkEn(1'b1),
        .sampleStrobe(sampleStrobe), .xRate(xRate), .yRate(yRate),
        .zRate(zRate), .opMode(opMode), .flagLatchEnable(latchEn),
        .xDetectEnable(detEn[0]), .yDetectEnable(detEn[1]),
        .zDetectEnable(detEn[2]), .debounceClearMode(dbMode),
        .rateLimitValue(limit), .debounceLength(dbLen), .regRead(regRead),
        .regAddr(regAddr), .readData(rdData), .readValid(rdValid),
        .anyAxisEvent(anyEvt));
    rtes_host host (.clk(clk), .readData(rdData), .readValid(rdValid),
        .regRead(regRead), .regAddr(regAddr));
    // ====================================================================
    // Helpers
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] st(input logic [2:0] f, input logic [2:0] s);
        return {1'b0, |f, f[2], s[2], f[1], s[1], f[0], s[0]};
    endfunction
    task automatic smp(input logic [15:0] x, y, z);
        @(posedge clk) #1;
        {xRate, yRate, zRate} = {x, y, z};
        sampleStrobe = 1'b1;
        @(posedge clk) #1;
        sampleStrobe = 1'b0;
    endtask
    task automatic enter(input rtes_pkg::rtes_mode_t m);
        @(posedge clk) #1;
        opMode = m;
        @(posedge clk) #1;
        opMode = rtes_pkg::RTES_ACTIVE;
    endtask
    task automatic chk_read(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        comparisons++;
        if (v !== 1'b1 || d !== e) begin
            fails++;
            $display("wrong value at %0t: read %h want %h", $time, d, e);
        end
    endtask
    task automatic chk_any(input logic e);
        comparisons++;
        if (anyEvt !== e) begin
            fails++;
            $display("wrong value at %0t: event %b want %b", $time, anyEvt, e);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ====================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        chk_read(OFF, 8'h00);
        chk_read(8'h0e, 8'h00);
        lfsr = nx(lfsr);
        limit = 7'(lfsr[1:0]);
        t = 16'((int'(limit) + 1) * 256);
        enter(rtes_pkg::RTES_STANDBY);
        repeat (2) smp(t, t + 16'h0001, ~t);
        chk_read(OFF, st(3'b000, 3'b100));
        smp(t, t + 16'h0001, ~t);
        chk_any(1'b1);
        chk_read(OFF, st(3'b110, 3'b100));
        repeat (2) smp(16'h0000, 16'h0010, 16'hfff0);
        chk_read(OFF, st(3'b110, 3'b100));
        smp(16'h0000, 16'h0010, 16'hfff0);
        chk_read(OFF, st(3'b000, 3'b100));
        enter(rtes_pkg::RTES_READY);
        chk_read(OFF, 8'h00);
        dbMode = 1'b0;
        for (int i = 0; i < 5; i++) begin
            smp(16'h0000, 16'h0000, i == 2 ? 16'h0000 : t + 16'h0001);
        end
        chk_read(OFF, st(3'b100, 3'b000));
        latchEn = 1'b1;
        dbLen = 8'h01;
        enter(rtes_pkg::RTES_STANDBY);
        smp(~t, t + 16'h0001, 16'h0000);
        chk_read(OFF, st(3'b011, 3'b001));
        chk_any(1'b0);
        chk_read(OFF, 8'h00);
        {latchEn, detEn} = 4'h0;
        enter(rtes_pkg::RTES_READY);
        smp(~t, ~t, ~t);
        chk_read(OFF, 8'h00);
        {detEn, dbLen} = {3'b111, 8'hff};
        enter(rtes_pkg::RTES_STANDBY);
        repeat (4) begin
            lfsr = nx(lfsr);
            smp(lfsr, ~lfsr, {lfsr[7:0], lfsr[15:8]});
            t = {8'h00, lfsr[7], ~lfsr[15], lfsr[15], 5'h00};
            chk_read(OFF, st(3'b000, t[7:5]));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
